// ===== core/spmc_top.sv
// switch power mode controller: mode register, energy detect, soft power-down, port power-down, EEE
//
// Contract
// - mode field: 00 normal, 01 energy detect, 10 soft power-down, 11 reserved.
// - after reset the mode field holds the normal-operation code.
// - normal mode: clocks run, PHYs and MACs on, host interface ready.
// - energy mode: no energy longer than go-sleep time enters low power.
// - low power: only receive energy detect stays on.
// - low power: one 120 ns pulse per second on the cable.
// - low power: energy seen returns the device to normal power.
// - energy mode normal power: ports transmit and receive frames.
// - soft power-down: clocks stopped, PHYs and MACs off.
// - host access in soft power-down: back to normal plus internal reset.
// - a port powers down on its control bit or its PHY bit 11.
// - each direction enters idle independently.
// - idle transitions keep link and never cut a frame.
// - idle phase gates unused MAC and switch clocks.
// - idle capability is exchanged with the link partner.
// - while requested send assert-idle, hold frames; after drop, delay then allow.
// - normal-to-assert-idle on receive raises partner idle; other encoding drops it.
// - idle only when both ends advertised capability.
`timescale 1ns/1ps
`default_nettype none
`include "spmc_defines.svh"

module spmc_top #(
   parameter int NPORT            = 4,
   parameter int SLEEP_TICK_CYC   = `SPMC_SLEEP_TICK_CYC,
   parameter int PULSE_PERIOD_CYC = `SPMC_PULSE_PERIOD_CYC,
   parameter int LPI_WAKE_CYC     = `SPMC_LPI_WAKE_CYC
) (
   input  wire logic             CLK_IN,
   input  wire logic             SRST_IN,
   input  wire logic [7:0]       ADDR_IN,
   input  wire logic [7:0]       WDATA_IN,
   input  wire logic             WR_IN,
   input  wire logic             RD_IN,
   output logic      [7:0]       RDATA_OUT,
   input  wire logic [NPORT-1:0] ENERGY_IN,
   input  wire logic [NPORT-1:0] PHY_CTRL_PD_IN,
   input  wire logic [NPORT-1:0] PARTNER_EEE_ADV_IN,
   input  wire logic [NPORT-1:0] LPI_TX_REQ_IN,
   input  wire logic [NPORT-1:0] TX_FRAME_ACTIVE_IN,
   input  wire logic [NPORT-1:0] RX_LPI_ENC_IN,
   input  wire logic [NPORT-1:0] RX_IDLE_ENC_IN,
   output logic                  PLL_EN_OUT,
   output logic                  HOST_IF_EN_OUT,
   output logic                  SW_CLK_EN_OUT,
   output logic                  RX_ED_EN_OUT,
   output logic                  LINK_PULSE_OUT,
   output logic                  INT_RST_OUT,
   output logic                  LOW_POWER_OUT,
   output logic      [NPORT-1:0] PHY_EN_OUT,
   output logic      [NPORT-1:0] MAC_EN_OUT,
   output logic      [NPORT-1:0] MAC_CLK_EN_OUT,
   output logic      [NPORT-1:0] TX_LPI_ENC_OUT,
   output logic      [NPORT-1:0] MAC_TX_ALLOW_OUT,
   output logic      [NPORT-1:0] PARTNER_IDLE_IND_OUT
);

   spmc_pkg::spmc_mode_type mode_r;
   spmc_pkg::spmc_mode_type wr_mode;
   spmc_pkg::spmc_ed_type   ed_r;
   logic [7:0]              go_sleep_r;
   logic [NPORT-1:0]        port_pd_r;
   logic [NPORT-1:0]        eee_adv_r;
   logic                    soft_wake;
   logic                    reg_rst;
   logic                    host_ok;
   logic                    host_wr;
   logic                    full_power;
   logic                    any_energy;
   logic [31:0]             tick_cnt_r;
   logic [8:0]              idle_ticks_r;
   logic [31:0]             pulse_cnt_r;
   logic [7:0]              rdata_r;
   logic [7:0]              rdata_nxt;
   logic                    int_rst_r;
   logic [NPORT-1:0]        eee_en;
   logic [NPORT-1:0]        tx_lpi_enc;
   logic [NPORT-1:0]        partner_idle;
   logic [NPORT-1:0]        port_idle;

   // any strobe while powered down wakes the device
   assign soft_wake = (mode_r == spmc_pkg::SPMC_MODE_SOFT_PD) && (WR_IN || RD_IN);
   assign reg_rst   = SRST_IN || soft_wake;

   // host port dead while asleep or powered down
   assign host_ok    = (mode_r == spmc_pkg::SPMC_MODE_NORMAL) ||
                       ((mode_r == spmc_pkg::SPMC_MODE_ENERGY) && (ed_r == spmc_pkg::SPMC_ED_AWAKE));
   assign host_wr    = WR_IN && host_ok;
   assign full_power = host_ok;
   assign any_energy = |ENERGY_IN;

   // decode of the written mode field
   assign wr_mode = spmc_pkg::spmc_mode_type'(WDATA_IN[`SPMC_MODE_MSB:`SPMC_MODE_LSB]);

   // mode register; the wake access itself is consumed by the internal reset
   always_ff @(posedge CLK_IN)
   begin
      if (reg_rst)
         mode_r <= spmc_pkg::SPMC_MODE_NORMAL;
      else if (host_wr && (ADDR_IN == `SPMC_ADDR_MODE) && (wr_mode != spmc_pkg::SPMC_MODE_RSVD))
         mode_r <= wr_mode;
   end

   // configuration registers, all restored by either reset source
   always_ff @(posedge CLK_IN)
   begin
      if (reg_rst)
      begin
         go_sleep_r <= `SPMC_GO_SLEEP_RST;
         port_pd_r  <= NPORT'(`SPMC_PORT_PD_RST);
         eee_adv_r  <= NPORT'(`SPMC_EEE_ADV_RST);
      end
      else if (host_wr)
      begin
         if (ADDR_IN == `SPMC_ADDR_GO_SLEEP)
            go_sleep_r <= WDATA_IN;
         if (ADDR_IN == `SPMC_ADDR_PORT_PD)
            port_pd_r <= WDATA_IN[NPORT-1:0];
         if (ADDR_IN == `SPMC_ADDR_EEE_ADV)
            eee_adv_r <= WDATA_IN[NPORT-1:0];
      end
   end

   // internal reset pulse, visible one cycle after the wake access
   always_ff @(posedge CLK_IN)
   begin
      if (SRST_IN)
         int_rst_r <= 1'b0;
      else
         int_rst_r <= soft_wake;
   end

   // go-sleep time base; one tick is one unit of the go-sleep field
   always_ff @(posedge CLK_IN)
   begin
      if (reg_rst || any_energy || (mode_r != spmc_pkg::SPMC_MODE_ENERGY) || (tick_cnt_r == 32'(SLEEP_TICK_CYC - 1)))
         tick_cnt_r <= 32'h0000_0000;
      else
         tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
   end

   always_ff @(posedge CLK_IN)
   begin
      if (reg_rst || any_energy || (mode_r != spmc_pkg::SPMC_MODE_ENERGY))
         idle_ticks_r <= 9'h000;
      else if ((tick_cnt_r == 32'(SLEEP_TICK_CYC - 1)) && (idle_ticks_r != 9'h1FF))
         idle_ticks_r <= idle_ticks_r + 9'h001;
   end

   // energy-detect sub-state; leaving energy mode always lands awake
   always_ff @(posedge CLK_IN)
   begin
      if (reg_rst || (mode_r != spmc_pkg::SPMC_MODE_ENERGY))
         ed_r <= spmc_pkg::SPMC_ED_AWAKE;
      else
      begin
         unique case (ed_r)
            spmc_pkg::SPMC_ED_AWAKE:
               if (!any_energy && (idle_ticks_r > {1'b0, go_sleep_r}))
                  ed_r <= spmc_pkg::SPMC_ED_ASLEEP;
            spmc_pkg::SPMC_ED_ASLEEP:
               if (any_energy)
                  ed_r <= spmc_pkg::SPMC_ED_AWAKE;
         endcase
      end
   end

   always_ff @(posedge CLK_IN)
   begin
      if (reg_rst || (ed_r != spmc_pkg::SPMC_ED_ASLEEP) || (pulse_cnt_r == 32'(PULSE_PERIOD_CYC - 1)))
         pulse_cnt_r <= 32'h0000_0000;
      else
         pulse_cnt_r <= pulse_cnt_r + 32'h0000_0001;
   end

   always_ff @(posedge CLK_IN)
   begin
      if (reg_rst)
         LINK_PULSE_OUT <= 1'b0;
      else
         LINK_PULSE_OUT <= (ed_r == spmc_pkg::SPMC_ED_ASLEEP) && !any_energy &&
                           (pulse_cnt_r < 32'(`SPMC_PULSE_CYC));
   end

   assign eee_en = eee_adv_r & PARTNER_EEE_ADV_IN;

   // one idle sequencer per port; each direction stands alone
   genvar g;
   generate
      for (g = 0; g < NPORT; g = g + 1)
      begin : g_port
         spmc_port_lpi #(
            .WAKE_CYC (LPI_WAKE_CYC)
         ) u_lpi (
            .clk_in             (CLK_IN),
            .srst_in            (reg_rst),
            .eee_en_in          (eee_en[g] && full_power),
            .tx_req_in          (LPI_TX_REQ_IN[g]),
            .tx_frame_active_in (TX_FRAME_ACTIVE_IN[g]),
            .rx_lpi_enc_in      (RX_LPI_ENC_IN[g]),
            .rx_idle_enc_in     (RX_IDLE_ENC_IN[g]),
            .tx_lpi_enc_out     (tx_lpi_enc[g]),
            .mac_tx_allow_out   (MAC_TX_ALLOW_OUT[g]),
            .partner_idle_out   (partner_idle[g])
         );
      end
   endgenerate

   assign TX_LPI_ENC_OUT       = tx_lpi_enc;
   assign PARTNER_IDLE_IND_OUT = partner_idle;
   assign port_idle = tx_lpi_enc & partner_idle;

   // power enables; registered so the gating cells never see glitches
   always_ff @(posedge CLK_IN)
   begin
      if (SRST_IN)
      begin
         PLL_EN_OUT     <= 1'b1;
         HOST_IF_EN_OUT <= 1'b1;
         SW_CLK_EN_OUT  <= 1'b1;
         RX_ED_EN_OUT   <= 1'b1;
         PHY_EN_OUT     <= {NPORT{1'b1}};
         MAC_EN_OUT     <= {NPORT{1'b1}};
         MAC_CLK_EN_OUT <= {NPORT{1'b1}};
      end
      else
      begin
         // full power in normal; likewise when awake in energy mode
         PLL_EN_OUT     <= full_power;
         HOST_IF_EN_OUT <= full_power;
         RX_ED_EN_OUT   <= (mode_r != spmc_pkg::SPMC_MODE_SOFT_PD);
         PHY_EN_OUT     <= {NPORT{full_power}} & ~port_pd_r & ~PHY_CTRL_PD_IN;
         MAC_EN_OUT     <= {NPORT{full_power}};
         MAC_CLK_EN_OUT <= {NPORT{full_power}} & ~port_idle;
         SW_CLK_EN_OUT  <= full_power && !(&port_idle);
      end
   end

   assign INT_RST_OUT   = int_rst_r;
   assign LOW_POWER_OUT = (ed_r == spmc_pkg::SPMC_ED_ASLEEP);

   // read mux; unmapped offsets and a dead host port read as zero
   always_comb
   begin
      rdata_nxt = `SPMC_RDATA_ZERO;
      if (RD_IN && host_ok)
      begin
         unique case (ADDR_IN)
            `SPMC_ADDR_MODE:
               rdata_nxt[`SPMC_MODE_MSB:`SPMC_MODE_LSB] = mode_r;
            `SPMC_ADDR_GO_SLEEP:
               rdata_nxt = go_sleep_r;
            `SPMC_ADDR_PORT_PD:
               rdata_nxt[NPORT-1:0] = port_pd_r;
            `SPMC_ADDR_EEE_ADV:
               rdata_nxt[NPORT-1:0] = eee_adv_r;
            `SPMC_ADDR_PWR_STAT:
            begin
               rdata_nxt[`SPMC_STAT_LOW_BIT]  = (ed_r == spmc_pkg::SPMC_ED_ASLEEP);
               rdata_nxt[`SPMC_STAT_SOFT_BIT] = (mode_r == spmc_pkg::SPMC_MODE_SOFT_PD);
               rdata_nxt[`SPMC_STAT_ED_BIT]   = any_energy;
            end
            `SPMC_ADDR_EEE_STAT:
               rdata_nxt = 8'({partner_idle, tx_lpi_enc});
            default:
               rdata_nxt = `SPMC_RDATA_ZERO;
         endcase
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge CLK_IN)
   begin
      if (SRST_IN)
         rdata_r <= `SPMC_RDATA_ZERO;
      else
         rdata_r <= rdata_nxt;
   end

   assign RDATA_OUT = rdata_r;

endmodule // spmc_top
`default_nettype wire

// ===== core/spmc_defines.svh
// register offsets, field positions, reset values and timing figures of the power mode controller
`ifndef SPMC_DEFINES_SVH
`define SPMC_DEFINES_SVH

// register offsets (byte addresses on the plain register port)
`define SPMC_ADDR_MODE       8'h00
`define SPMC_ADDR_GO_SLEEP   8'h01
`define SPMC_ADDR_PORT_PD    8'h02
`define SPMC_ADDR_EEE_ADV    8'h03
`define SPMC_ADDR_PWR_STAT   8'h04
`define SPMC_ADDR_EEE_STAT   8'h05

// field positions
`define SPMC_MODE_LSB        3
`define SPMC_MODE_MSB        4
`define SPMC_STAT_LOW_BIT    0
`define SPMC_STAT_SOFT_BIT   1
`define SPMC_STAT_ED_BIT     2

// reset values
`define SPMC_GO_SLEEP_RST    8'h10
`define SPMC_PORT_PD_RST     8'h00
`define SPMC_EEE_ADV_RST     8'h00
`define SPMC_RDATA_ZERO      8'h00

// timing figures in their own units
`define SPMC_CLK_PERIOD_NS   100
`define SPMC_PULSE_WIDTH_NS  120
`define SPMC_PULSE_PERIOD_MS 1000
`define SPMC_SLEEP_TICK_US   1000
`define SPMC_LPI_WAKE_US     30

// derived cycle counts: least times round up, periods are exact multiples here
`define SPMC_PULSE_CYC ((`SPMC_PULSE_WIDTH_NS + `SPMC_CLK_PERIOD_NS - 1) / `SPMC_CLK_PERIOD_NS)
`define SPMC_PULSE_PERIOD_CYC ((`SPMC_PULSE_PERIOD_MS * 1000000) / `SPMC_CLK_PERIOD_NS)
`define SPMC_SLEEP_TICK_CYC ((`SPMC_SLEEP_TICK_US * 1000) / `SPMC_CLK_PERIOD_NS)
`define SPMC_LPI_WAKE_CYC (((`SPMC_LPI_WAKE_US * 1000) + `SPMC_CLK_PERIOD_NS - 1) / `SPMC_CLK_PERIOD_NS)

`endif

// ===== core/spmc_pkg.sv
// types shared by the power mode controller files
package spmc_pkg;

   // global power mode field, codes follow declaration order 00, 01, 10, 11
   typedef enum logic [1:0] {
      SPMC_MODE_NORMAL,
      SPMC_MODE_ENERGY,
      SPMC_MODE_SOFT_PD,
      SPMC_MODE_RSVD
   } spmc_mode_type;

   // energy-detect sub-state
   typedef enum logic {
      SPMC_ED_AWAKE,
      SPMC_ED_ASLEEP
   } spmc_ed_type;

   // per-port transmit low-power idle sequence
   typedef enum logic [1:0] {
      SPMC_LPI_ACTIVE,
      SPMC_LPI_ASSERT,
      SPMC_LPI_WAKE
   } spmc_lpi_type;

endpackage

// ===== core/spmc_port_lpi.sv
// per-port low-power idle transmit sequencing and receive idle detection
`timescale 1ns/1ps
`default_nettype none
`include "spmc_defines.svh"

module spmc_port_lpi #(
   parameter int WAKE_CYC = `SPMC_LPI_WAKE_CYC
) (
   input  wire logic clk_in,
   input  wire logic srst_in,
   input  wire logic eee_en_in,
   input  wire logic tx_req_in,
   input  wire logic tx_frame_active_in,
   input  wire logic rx_lpi_enc_in,
   input  wire logic rx_idle_enc_in,
   output logic      tx_lpi_enc_out,
   output logic      mac_tx_allow_out,
   output logic      partner_idle_out
);

   spmc_pkg::spmc_lpi_type state_r;
   spmc_pkg::spmc_lpi_type state_nxt;
   logic [15:0]            wake_cnt_r;
   logic                   prev_idle_r;
   logic                   tx_lpi_enc_r;
   logic                   partner_idle_r;

   // next transmit state; a request waits for the current frame to end so nothing is cut
   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         spmc_pkg::SPMC_LPI_ACTIVE:
            if (eee_en_in && tx_req_in && !tx_frame_active_in)
               state_nxt = spmc_pkg::SPMC_LPI_ASSERT;
         spmc_pkg::SPMC_LPI_ASSERT:
            if (!tx_req_in || !eee_en_in)
               state_nxt = spmc_pkg::SPMC_LPI_WAKE;
         spmc_pkg::SPMC_LPI_WAKE:
            if (wake_cnt_r == 16'(WAKE_CYC - 1))
               state_nxt = spmc_pkg::SPMC_LPI_ACTIVE;
      endcase
   end

   // state register and wake hold-off counter
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         state_r    <= spmc_pkg::SPMC_LPI_ACTIVE;
         wake_cnt_r <= 16'h0000;
      end
      else
      begin
         state_r    <= state_nxt;
         wake_cnt_r <= (state_r == spmc_pkg::SPMC_LPI_WAKE) ? wake_cnt_r + 16'h0001 : 16'h0000;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
         tx_lpi_enc_r <= 1'b0;
      else
         tx_lpi_enc_r <= (state_nxt == spmc_pkg::SPMC_LPI_ASSERT);
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         prev_idle_r    <= 1'b0;
         partner_idle_r <= 1'b0;
      end
      else
      begin
         prev_idle_r <= rx_idle_enc_in;
         if (!rx_lpi_enc_in || !eee_en_in)
            partner_idle_r <= 1'b0;
         else if (prev_idle_r)
            partner_idle_r <= 1'b1;
      end
   end

   // frames allowed only outside assert and wake
   assign mac_tx_allow_out = (state_r == spmc_pkg::SPMC_LPI_ACTIVE);
   assign tx_lpi_enc_out   = tx_lpi_enc_r;
   assign partner_idle_out = partner_idle_r;

endmodule // spmc_port_lpi
`default_nettype wire

// ===== dv/spmc_top_props.sv
// assertion checker for the power mode controller, bound to its top module
`timescale 1ns/1ps
`default_nettype none

module spmc_top_props #(
   parameter int NPORT = 4
) (
   input wire logic             CLK_IN,
   input wire logic             SRST_IN,
   input wire logic             WR_IN,
   input wire logic             RD_IN,
   input wire logic [7:0]       RDATA_OUT,
   input wire logic [NPORT-1:0] ENERGY_IN,
   input wire logic [NPORT-1:0] PARTNER_EEE_ADV_IN,
   input wire logic [NPORT-1:0] LPI_TX_REQ_IN,
   input wire logic [NPORT-1:0] TX_FRAME_ACTIVE_IN,
   input wire logic [NPORT-1:0] RX_LPI_ENC_IN,
   input wire logic [NPORT-1:0] RX_IDLE_ENC_IN,
   input wire logic             PLL_EN_OUT,
   input wire logic             HOST_IF_EN_OUT,
   input wire logic             RX_ED_EN_OUT,
   input wire logic             LINK_PULSE_OUT,
   input wire logic             INT_RST_OUT,
   input wire logic             LOW_POWER_OUT,
   input wire logic [NPORT-1:0] MAC_EN_OUT,
   input wire logic [NPORT-1:0] TX_LPI_ENC_OUT,
   input wire logic [NPORT-1:0] MAC_TX_ALLOW_OUT,
   input wire logic [NPORT-1:0] PARTNER_IDLE_IND_OUT
);
   // one clock domain, so clocking and reset are given once
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (SRST_IN);

   // tail of a link pulse: high once more, then low
   sequence pulse_tail_s;
      LINK_PULSE_OUT ##1 !LINK_PULSE_OUT;
   endsequence

   // read data stand only after a read strobe
   rdata_idle_a: assert property (!$past(RD_IN) |-> RDATA_OUT == 8'h00)
      else $error("read data outside read slot");
   sleep_entry_a: assert property ($rose(LOW_POWER_OUT) |-> $past(ENERGY_IN) == '0 && $past(ENERGY_IN, 2) == '0)
      else $error("sleep entered with energy");
   low_gate_a: assert property (LOW_POWER_OUT [*2] |-> !PLL_EN_OUT && !HOST_IF_EN_OUT && RX_ED_EN_OUT && MAC_EN_OUT == '0)
      else $error("enables wrong while asleep");
   pulse_width_a: assert property ($rose(LINK_PULSE_OUT) |-> $past(LOW_POWER_OUT) ##1 pulse_tail_s)
      else $error("link pulse wrong");
   wake_a: assert property (LOW_POWER_OUT && ENERGY_IN != '0 |=> !LOW_POWER_OUT)
      else $error("no wake on energy");
   int_rst_a: assert property ($rose(INT_RST_OUT) |-> ($past(WR_IN) || $past(RD_IN)) ##1 !INT_RST_OUT)
      else $error("internal reset pulse wrong");
   lpi_hold_a: assert property ((TX_LPI_ENC_OUT & MAC_TX_ALLOW_OUT) == '0)
      else $error("frames allowed during idle");
   lpi_entry_a:
      assert property ((TX_LPI_ENC_OUT & ~$past(TX_LPI_ENC_OUT) & ~($past(PARTNER_EEE_ADV_IN)
         & $past(LPI_TX_REQ_IN) & ~$past(TX_FRAME_ACTIVE_IN))) == '0)
      else $error("idle entered without cause");
   idle_rise_a:
      assert property ((PARTNER_IDLE_IND_OUT & ~$past(PARTNER_IDLE_IND_OUT)
         & ~($past(RX_LPI_ENC_IN) & $past(RX_IDLE_ENC_IN, 2))) == '0)
      else $error("partner idle rose without transition");
   idle_fall_a: assert property ((PARTNER_IDLE_IND_OUT & ~$past(RX_LPI_ENC_IN)) == '0)
      else $error("partner idle kept");
endmodule // spmc_top_props

bind spmc_top spmc_top_props #(.NPORT(NPORT)) i_props (
   .CLK_IN(CLK_IN), .SRST_IN(SRST_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
   .ENERGY_IN(ENERGY_IN), .PARTNER_EEE_ADV_IN(PARTNER_EEE_ADV_IN), .LPI_TX_REQ_IN(LPI_TX_REQ_IN),
   .TX_FRAME_ACTIVE_IN(TX_FRAME_ACTIVE_IN), .RX_LPI_ENC_IN(RX_LPI_ENC_IN), .RX_IDLE_ENC_IN(RX_IDLE_ENC_IN),
   .PLL_EN_OUT(PLL_EN_OUT), .HOST_IF_EN_OUT(HOST_IF_EN_OUT), .RX_ED_EN_OUT(RX_ED_EN_OUT),
   .LINK_PULSE_OUT(LINK_PULSE_OUT), .INT_RST_OUT(INT_RST_OUT), .LOW_POWER_OUT(LOW_POWER_OUT),
   .MAC_EN_OUT(MAC_EN_OUT), .TX_LPI_ENC_OUT(TX_LPI_ENC_OUT), .MAC_TX_ALLOW_OUT(MAC_TX_ALLOW_OUT),
   .PARTNER_IDLE_IND_OUT(PARTNER_IDLE_IND_OUT)
);
`default_nettype wire

// ===== dv/spmc_link_partner.sv
// link partner model: cable energy, receive encodings and idle advertisement per port
`timescale 1ns/1ps
`default_nettype none

module spmc_link_partner #(
   parameter int NPORT = 4
) (
   input  wire logic [NPORT-1:0] energy_cmd_in,
   input  wire logic [NPORT-1:0] lpi_cmd_in,
   input  wire logic [NPORT-1:0] adv_cmd_in,
   output logic      [NPORT-1:0] energy_out,
   output logic      [NPORT-1:0] rx_lpi_enc_out,
   output logic      [NPORT-1:0] rx_idle_enc_out,
   output logic      [NPORT-1:0] eee_adv_out
);
   // cable energy follows the plug state at once, the fastest partner
   assign energy_out = energy_cmd_in;

   // assert-idle while the partner idles, normal inter-frame otherwise, never both
   assign rx_lpi_enc_out  = lpi_cmd_in;
   assign rx_idle_enc_out = ~lpi_cmd_in;

   // capability exchange
   // zero until the idle test sets it once; a real partner changes it only on renegotiation
   assign eee_adv_out = adv_cmd_in;
endmodule // spmc_link_partner
`default_nettype wire

// ===== dv/tb_top.sv
// self-checking bench for the switch power mode controller
`timescale 1ns/1ps
`default_nettype none
`include "spmc_defines.svh"

module tb_top;
   localparam int NP  = 4;
   localparam int PER = 20;
   logic          clk, srst, wr, rd, pll, hif, swc, red, pulse, irst, lowp;
   logic [7:0]    addr, wdata, rdata;
   logic [NP-1:0] e_cmd, l_cmd, a_cmd, energy, rx_lpi, rx_idle, adv;
   logic [NP-1:0] pd_in, req, fa, phy, mac, mck, enc, allow, pidle;
   int            bad_count, n_tests;

   // short counts keep tick, pulse period and wake delay visible in a brief run
   spmc_top #(.NPORT(NP), .SLEEP_TICK_CYC(4), .PULSE_PERIOD_CYC(PER), .LPI_WAKE_CYC(3)) i_dut (
      .CLK_IN(clk), .SRST_IN(srst), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
      .RDATA_OUT(rdata), .ENERGY_IN(energy), .PHY_CTRL_PD_IN(pd_in), .PARTNER_EEE_ADV_IN(adv),
      .LPI_TX_REQ_IN(req), .TX_FRAME_ACTIVE_IN(fa), .RX_LPI_ENC_IN(rx_lpi), .RX_IDLE_ENC_IN(rx_idle),
      .PLL_EN_OUT(pll), .HOST_IF_EN_OUT(hif), .SW_CLK_EN_OUT(swc), .RX_ED_EN_OUT(red),
      .LINK_PULSE_OUT(pulse), .INT_RST_OUT(irst), .LOW_POWER_OUT(lowp), .PHY_EN_OUT(phy),
      .MAC_EN_OUT(mac), .MAC_CLK_EN_OUT(mck), .TX_LPI_ENC_OUT(enc), .MAC_TX_ALLOW_OUT(allow),
      .PARTNER_IDLE_IND_OUT(pidle)
   );

   spmc_link_partner #(.NPORT(NP)) i_partner (
      .energy_cmd_in(e_cmd), .lpi_cmd_in(l_cmd), .adv_cmd_in(a_cmd), .energy_out(energy),
      .rx_lpi_enc_out(rx_lpi), .rx_idle_enc_out(rx_idle), .eee_adv_out(adv)
   );

   // 10 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // compare one value, counting every comparison
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // write: one strobe cycle
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   // read: data stand only in the cycle after the strobe
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      @(negedge clk);
      chk(rdata, exp);
   endtask

   // wait n edges, then sample mid-cycle where outputs have settled
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   // count cycles while pulse or low power keeps its level; bounded so a stuck output cannot hang
   // sampled mid-cycle so the level is never read in the time step of the edge that launches it
   task automatic hold(input bit sel, input logic lvl, inout int n);
      while ((sel ? pulse : lowp) === lvl && n < 60)
      begin
         @(negedge clk);
         n++;
      end
   endtask

   task automatic report_and_stop;
      if (bad_count == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic t_reset;
      rchk(`SPMC_ADDR_MODE, 8'h00);
      rchk(8'h7F, 8'h00);
      chk({pll, hif, swc, red, phy}, 8'hFF);
      chk({mac, mck}, 8'hFF);
   endtask

   // reserved code is ignored even outside normal mode
   task automatic t_rsvd;
      wreg(`SPMC_ADDR_MODE, 8'h08);
      rchk(`SPMC_ADDR_MODE, 8'h08);
      wreg(`SPMC_ADDR_MODE, 8'h18);
      rchk(`SPMC_ADDR_MODE, 8'h08);
      wreg(`SPMC_ADDR_MODE, 8'h00);
      rchk(`SPMC_ADDR_MODE, 8'h00);
   endtask

   task automatic t_port;
      wreg(`SPMC_ADDR_PORT_PD, 8'h01);
      pd_in <= 4'h4;
      cyc(2);
      chk({4'h0, phy}, 8'h0A);
      wreg(`SPMC_ADDR_PORT_PD, 8'h00);
      pd_in <= 4'h0;
   endtask

   task automatic t_energy;
      int n;
      wreg(`SPMC_ADDR_GO_SLEEP, 8'h01);
      wreg(`SPMC_ADDR_MODE, 8'h08);
      n = 0;
      hold(1'b0, 1'b0, n);
      chk(8'(n > 4 && n <= 14), 8'h01);
      cyc(2);
      chk({mac, pll, hif, red, swc}, 8'h02);
      n = 0;
      hold(1'b1, 1'b1, n);
      hold(1'b1, 1'b0, n);
      n = 0;
      hold(1'b1, 1'b1, n);
      chk(8'(n), 8'h02);
      hold(1'b1, 1'b0, n);
      chk(8'(n), 8'(PER));
      @(posedge clk);
      e_cmd <= 4'h4;
      cyc(3);
      chk({3'h0, lowp, mac}, 8'h0F);
      rchk(`SPMC_ADDR_PWR_STAT, 8'h04);
      wreg(`SPMC_ADDR_MODE, 8'h00);
      e_cmd <= 4'h0;
   endtask

   task automatic t_soft;
      wreg(`SPMC_ADDR_GO_SLEEP, 8'h33);
      wreg(`SPMC_ADDR_MODE, 8'h10);
      cyc(2);
      chk({pll, hif, swc, 1'b0, mac}, 8'h00);
      chk({4'h0, phy}, 8'h00);
      rchk(`SPMC_ADDR_MODE, 8'h00);
      chk({7'h00, irst}, 8'h01);
      cyc(2);
      rchk(`SPMC_ADDR_GO_SLEEP, 8'h10);
      chk({pll, hif, swc, 1'b0, phy}, 8'hEF);
   endtask

   // port 1 mid-frame, port 2 no request, port 3 partner not capable
   task automatic t_lpi;
      @(posedge clk);
      a_cmd <= 4'h7;
      fa    <= 4'h2;
      wreg(`SPMC_ADDR_EEE_ADV, 8'h0F);
      req   <= 4'hB;
      cyc(3);
      chk({enc, allow}, 8'h1E);
      @(posedge clk);
      fa    <= 4'h0;
      cyc(2);
      chk({enc, allow}, 8'h3C);
      @(posedge clk);
      l_cmd <= 4'h3;
      cyc(3);
      chk({pidle, mck}, 8'h3C);
      rchk(`SPMC_ADDR_EEE_STAT, 8'h33);
      @(posedge clk);
      req   <= 4'h0;
      cyc(3);
      chk({enc, allow}, 8'h0C);
      cyc(1);
      chk({enc, allow}, 8'h0F);
      @(posedge clk);
      l_cmd <= 4'h0;
      cyc(3);
      chk({pidle, mck}, 8'h0F);
   endtask

   // main sequence, reset held four cycles
   initial
   begin
      {srst, wr, rd} = 3'b100;
      addr  = 8'h00;
      wdata = 8'h00;
      {e_cmd, l_cmd, a_cmd, pd_in, req, fa} = '0;
      bad_count = 0;
      n_tests   = 0;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      t_reset;
      t_rsvd;
      t_port;
      t_energy;
      t_soft;
      t_lpi;
      report_and_stop;
   end

   // watchdog: the tests need about 125 cycles
   initial
   begin
      #(5000 * 100);
      bad_count++;
      report_and_stop;
   end
endmodule // tb_top
`default_nettype wire
